// file: include/gcd_cfg.svh
`ifndef GCD_CFG_SVH
`define GCD_CFG_SVH
// --------------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define GCD_IDX_RTA 10'h002
`define GCD_IDX_DV 10'h004
`define GCD_IDX_ICC 10'h00c
`define GCD_IDX_PACK 10'h028
`define GCD_IDX_GAUGE 10'h029
`define GCD_IDX_FILT 10'h02c
`define GCD_IDX_DCAP 10'h032
`define GCD_IDX_FULLINIT 10'h036
`define GCD_IDX_CCT 10'h037
`define GCD_IDX_CHGEFF 10'h054
`define GCD_IDX_GAIN 10'h0cb
`define GCD_IDX_DELTA 10'h0cd
`define GCD_IDX_CCOFF 10'h0d2
`define GCD_IDX_GNDOFF 10'h0d4
`define GCD_IDX_ADCOFF 10'h0d5
`define GCD_IDX_CAPALM 10'h060
`define GCD_IDX_SYNCPCT 10'h061
`define GCD_IDX_EDVF0 10'h062
`define GCD_IDX_EDVF1 10'h063
`define GCD_IDX_EDVF2 10'h064
`define GCD_IDX_REMCAP 10'h070
`define GCD_IDX_FULLCAP 10'h071
`define GCD_IDX_CYC 10'h072
`define GCD_IDX_FLAGS 10'h073
// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define GCD_RST_HALF 16'h0000
`define GCD_RST_BYTE 8'h00
`define GCD_RST_CHGEFF 8'hff
`define GCD_RST_PCT 8'h64
`define GCD_RST_GAIN 16'h77a1
`define GCD_RST_DELTA 32'h0100_0000
// --------------------------------------------------------------------------
// Scale constants and status field positions
// --------------------------------------------------------------------------
`define GCD_PCT_DIV 24'd100
`define GCD_PWR_DIV 32'd10000
`define GCD_FILT_NV 9'd290
`define GCD_SOC_STEP 10'd100
`define GCD_POS_PEND 0
`define GCD_POS_OV 1
`define GCD_POS_EOD 2
`endif

// file: include/gcd_pkg.sv
package gcd_pkg;
  // Pack options byte, bit 7 down to bit 0
  typedef struct packed {
    logic led_soc_select;
    logic [1:0] led_count_field;
    logic host_alarm_check_enable;
    logic charger_broadcast_check_enable;
    logic broadcast_disable;
    logic [1:0] series_cell_count;
  } gcd_pack_opt_type;
  // Gauge options byte, bit 7 down to bit 0
  typedef struct packed {
    logic fixed_lowest_threshold;
    logic termination_capacity_sync;
    logic charger_type_select;
    logic threshold_compensation_enable;
    logic discharge_end_source;
    logic overvoltage_source_select;
    logic midrange_correction_enable;
    logic one_time_midrange_correction;
  } gcd_gauge_opt_type;
  // Three end-of-discharge thresholds in mV
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] middle;
    logic [15:0] lowest_discharge_threshold;
  } gcd_edv_type;
  // Software-visible store
  typedef struct packed {
    logic [15:0] remaining_time_alarm_setting;
    logic [15:0] design_voltage_setting;
    logic [15:0] initial_cycle_count;
    gcd_pack_opt_type pack_options;
    gcd_gauge_opt_type gauge_options;
    logic [7:0] filter_threshold;
    logic [15:0] pack_design_capacity;
    logic [15:0] learned_capacity_initial;
    logic [15:0] cycle_increment_threshold;
    logic [7:0] charge_efficiency_code;
    logic [15:0] current_scale_gain;
    logic [31:0] counter_gain_factor;
    logic [15:0] counter_offset;
    logic [7:0] ground_reference_offset;
    logic [7:0] converter_offset;
    logic [15:0] capacity_alarm_setting;
    logic [7:0] sync_percent;
    gcd_edv_type fixed_edv;
  } gcd_cfg_type;
  // Whole state of the block
  typedef struct packed {
    gcd_cfg_type cfg;
    logic [15:0] remaining_capacity;
    logic [15:0] learned_full_capacity;
    logic [15:0] cycle_count;
    logic [15:0] discharge_acc;
    logic one_time_pending;
    logic [4:0] led_on;
    gcd_edv_type edv;
    logic [15:0] eod_voltage;
    logic eod_reached;
    logic ov_trip;
    logic [15:0] design_capacity_report;
    logic [15:0] charge_mah;
    logic [16:0] filter_threshold_voltage;
    logic [31:0] prdata;
  } gcd_state_type;
endpackage

// file: design/gcd_top.sv
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "gcd_cfg.svh"
// Operation
// R1: LEDs follow absolute charge when select is 0, relative charge when 1.
// R2: LED count 00/11 five, 01 three, 10 four segments.
// R3: Host alarm check bit adds a check byte to alarm messages.
// R4: Charger check bit adds a check byte to charger broadcasts.
// R5: Broadcast disable bit stops all master broadcasts; clear enables both.
// R6: Battery-mode writes cannot re-enable broadcasts while disable is set.
// R7: Cell code 11 four, 10 three, 01 two series cells.
// R8: Fixed lowest threshold holds it; upper two never fall below it.
// R9: Capacity sync loads remaining capacity with percent of full at termination.
// R10: Charger type bit picks independent (1) or smart (0) learning.
// R11: Compensation on uses computed thresholds, off uses stored ones.
// R12: End of discharge judged on pack voltage (1) or lowest cell (0).
// R13: Overvoltage source bit chooses pack or highest cell voltage.
// R14: At 0 compare pack voltage, at 1 highest cell times count.
// R15: Midrange bit requests continuous voltage correction of remaining capacity.
// R16: One-time bit requests one midrange correction after each reset.
// R17: Offsets are rewritten from measurement when sleep is entered.
// R18: Converter result scaled by resistor gain, corrected by 32-bit gain.
// R19: Filter threshold voltage is stored value times 290 nV.
// R20: Design capacity reported as stored, or times voltage in 10 mWh.
// R21: Full capacity starts at stored initial value, updated after learning.
// R22: Time alarm and capacity alarm settings feed commands 0x01 and 0x02.
// R23: Cycle count increments whenever discharge reaches the threshold. Here a zero threshold never increments it.
// R24: Efficiency code applied to all charge added, as (code+1)/256.
// R25: Programmer should set initial cycle count to zero.
// R26: Cell count code 00 is reserved, reported as zero cells.
module gcd_top
  import gcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] abs_soc,
  input wire logic [6:0] rel_soc,
  input wire logic [15:0] conv_result,
  input wire logic conv_valid,
  input wire logic conv_charging,
  input wire logic charge_term,
  input wire logic learn_done,
  input wire logic [15:0] learned_capacity,
  input wire logic sleep_entry,
  input wire logic [15:0] meas_counter_offset,
  input wire logic [7:0] meas_ground_offset,
  input wire logic [7:0] meas_converter_offset,
  input wire gcd_edv_type comp_edv,
  input wire logic [15:0] pack_voltage,
  input wire logic [15:0] min_cell_voltage,
  input wire logic [15:0] max_cell_voltage,
  input wire logic [15:0] ov_limit,
  input wire logic power_mode,
  input wire logic mode_broadcast_on,
  input wire logic midrange_done,
  output logic [4:0] led_on,
  output logic host_alarm_pec,
  output logic charger_pec,
  output logic broadcast_en,
  output logic [2:0] cell_count,
  output logic charger_type_select,
  output gcd_edv_type edv,
  output logic [15:0] eod_voltage,
  output logic eod_reached,
  output logic ov_trip,
  output logic midrange_req,
  output logic [15:0] remaining_capacity,
  output logic [15:0] learned_full_capacity,
  output logic [15:0] cycle_count,
  output logic [15:0] design_capacity_report,
  output logic [15:0] time_alarm,
  output logic [15:0] capacity_alarm,
  output logic [15:0] charge_mah,
  output logic [16:0] filter_threshold_voltage
);
  gcd_state_type st_q;
  gcd_state_type st_d;
  gcd_pack_opt_type po;
  gcd_gauge_opt_type go;
  logic [9:0] idx;
  logic hit;
  logic [31:0] rdata;
  logic [2:0] n_seg;
  logic [9:0] soc_n;
  logic [4:0] led_next;

  assign po = st_q.cfg.pack_options;
  assign go = st_q.cfg.gauge_options;
  assign idx = paddr[11:2];

  // --------------------------------------------------------------------------
  // Display decode
  // --------------------------------------------------------------------------
  // Segment count and chosen charge figure
  always_comb begin
    unique case (po.led_count_field)
      2'b01: n_seg = 3'd3; // R2
      2'b10: n_seg = 3'd4; // R2
      2'b00, 2'b11: n_seg = 3'd5; // R2
    endcase
    soc_n = 10'(po.led_soc_select ? rel_soc : abs_soc) * 10'(n_seg); // R1
  end

  // Segment i lights once charge passes i steps of 100/n
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_seg
      assign led_next[gi] = (3'(gi) < n_seg) && (soc_n > 10'(gi) * `GCD_SOC_STEP); // R2
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Register map read mux
  // --------------------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    unique case (idx)
      `GCD_IDX_RTA: rdata = {16'h0000, st_q.cfg.remaining_time_alarm_setting};
      `GCD_IDX_DV: rdata = {16'h0000, st_q.cfg.design_voltage_setting};
      `GCD_IDX_ICC: rdata = {16'h0000, st_q.cfg.initial_cycle_count};
      `GCD_IDX_PACK: rdata = {24'h00_0000, st_q.cfg.pack_options};
      `GCD_IDX_GAUGE: rdata = {24'h00_0000, st_q.cfg.gauge_options};
      `GCD_IDX_FILT: rdata = {24'h00_0000, st_q.cfg.filter_threshold};
      `GCD_IDX_DCAP: rdata = {16'h0000, st_q.cfg.pack_design_capacity};
      `GCD_IDX_FULLINIT: rdata = {16'h0000, st_q.cfg.learned_capacity_initial};
      `GCD_IDX_CCT: rdata = {16'h0000, st_q.cfg.cycle_increment_threshold};
      `GCD_IDX_CHGEFF: rdata = {24'h00_0000, st_q.cfg.charge_efficiency_code};
      `GCD_IDX_GAIN: rdata = {16'h0000, st_q.cfg.current_scale_gain};
      `GCD_IDX_DELTA: rdata = st_q.cfg.counter_gain_factor;
      `GCD_IDX_CCOFF: rdata = {16'h0000, st_q.cfg.counter_offset};
      `GCD_IDX_GNDOFF: rdata = {24'h00_0000, st_q.cfg.ground_reference_offset};
      `GCD_IDX_ADCOFF: rdata = {24'h00_0000, st_q.cfg.converter_offset};
      `GCD_IDX_CAPALM: rdata = {16'h0000, st_q.cfg.capacity_alarm_setting};
      `GCD_IDX_SYNCPCT: rdata = {24'h00_0000, st_q.cfg.sync_percent};
      `GCD_IDX_EDVF0: rdata = {16'h0000, st_q.cfg.fixed_edv.lowest_discharge_threshold};
      `GCD_IDX_EDVF1: rdata = {16'h0000, st_q.cfg.fixed_edv.middle};
      `GCD_IDX_EDVF2: rdata = {16'h0000, st_q.cfg.fixed_edv.upper};
      `GCD_IDX_REMCAP: rdata = {16'h0000, st_q.remaining_capacity};
      `GCD_IDX_FULLCAP: rdata = {16'h0000, st_q.learned_full_capacity};
      `GCD_IDX_CYC: rdata = {16'h0000, st_q.cycle_count};
      `GCD_IDX_FLAGS: begin
        rdata[`GCD_POS_PEND] = st_q.one_time_pending;
        rdata[`GCD_POS_OV] = st_q.ov_trip;
        rdata[`GCD_POS_EOD] = st_q.eod_reached;
      end
      default: hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Bus writes first, then hardware events so that they win a collision
  always_comb begin
    logic wr;
    logic [31:0] sc1;
    logic [47:0] sc2;
    logic [24:0] added;
    logic [16:0] rsum;
    logic [16:0] dsum;
    logic [23:0] tgt;
    logic [31:0] pw;
    logic [18:0] ovv;
    gcd_edv_type pick;
    wr = 1'b0;
    sc1 = 32'h0;
    sc2 = 48'h0;
    added = 25'h0;
    rsum = 17'h0;
    dsum = 17'h0;
    tgt = 24'h0;
    pw = 32'h0;
    ovv = 19'h0;
    pick = comp_edv;
    st_d = st_q;
    wr = psel && penable && pwrite && hit;
    // Read data is latched in the setup phase and held through access
    if (psel && !penable) begin
      st_d.prdata = rdata;
    end
    if (wr) begin
      unique case (idx)
        `GCD_IDX_RTA: st_d.cfg.remaining_time_alarm_setting = pwdata[15:0];
        `GCD_IDX_DV: st_d.cfg.design_voltage_setting = pwdata[15:0];
        `GCD_IDX_ICC: begin
          st_d.cfg.initial_cycle_count = pwdata[15:0];
          st_d.cycle_count = pwdata[15:0]; // R25
        end
        `GCD_IDX_PACK: st_d.cfg.pack_options = pwdata[7:0];
        `GCD_IDX_GAUGE: st_d.cfg.gauge_options = pwdata[7:0];
        `GCD_IDX_FILT: st_d.cfg.filter_threshold = pwdata[7:0];
        `GCD_IDX_DCAP: st_d.cfg.pack_design_capacity = pwdata[15:0];
        `GCD_IDX_FULLINIT: begin
          st_d.cfg.learned_capacity_initial = pwdata[15:0];
          st_d.learned_full_capacity = pwdata[15:0]; // R21
        end
        `GCD_IDX_CCT: st_d.cfg.cycle_increment_threshold = pwdata[15:0];
        `GCD_IDX_CHGEFF: st_d.cfg.charge_efficiency_code = pwdata[7:0];
        `GCD_IDX_GAIN: st_d.cfg.current_scale_gain = pwdata[15:0];
        `GCD_IDX_DELTA: st_d.cfg.counter_gain_factor = pwdata;
        `GCD_IDX_CCOFF: st_d.cfg.counter_offset = pwdata[15:0];
        `GCD_IDX_GNDOFF: st_d.cfg.ground_reference_offset = pwdata[7:0];
        `GCD_IDX_ADCOFF: st_d.cfg.converter_offset = pwdata[7:0];
        `GCD_IDX_CAPALM: st_d.cfg.capacity_alarm_setting = pwdata[15:0];
        `GCD_IDX_SYNCPCT: st_d.cfg.sync_percent = pwdata[7:0];
        `GCD_IDX_EDVF0: st_d.cfg.fixed_edv.lowest_discharge_threshold = pwdata[15:0];
        `GCD_IDX_EDVF1: st_d.cfg.fixed_edv.middle = pwdata[15:0];
        `GCD_IDX_EDVF2: st_d.cfg.fixed_edv.upper = pwdata[15:0];
        default: ; // Status words ignore writes
      endcase
    end
    // Calibration refresh before sleep overrides a colliding bus write
    if (sleep_entry) begin
      st_d.cfg.counter_offset = meas_counter_offset; // R17
      st_d.cfg.ground_reference_offset = meas_ground_offset; // R17
      st_d.cfg.converter_offset = meas_converter_offset; // R17
    end
    // Conversion to mAh: gain is 2^-16 scaled, gain factor unity at 2^24
    sc1 = 32'(conv_result) * 32'(st_q.cfg.current_scale_gain); // R18
    sc2 = 48'(sc1[31:16]) * 48'(st_q.cfg.counter_gain_factor); // R18
    if (conv_valid) begin
      st_d.charge_mah = sc2[39:24]; // R18
      if (conv_charging) begin
        added = 25'(sc2[39:24]) * 25'({1'b0, st_q.cfg.charge_efficiency_code} + 9'd1); // R24
        rsum = 17'(st_q.remaining_capacity) + 17'(added[23:8]); // R24
        // Charge counting saturates at the learned full capacity
        if (rsum > 17'(st_q.learned_full_capacity)) begin
          st_d.remaining_capacity = st_q.learned_full_capacity;
        end else begin
          st_d.remaining_capacity = rsum[15:0];
        end
      end else begin
        if (sc2[39:24] > st_q.remaining_capacity) begin
          st_d.remaining_capacity = 16'h0000;
        end else begin
          st_d.remaining_capacity = st_q.remaining_capacity - sc2[39:24];
        end
        dsum = 17'(st_q.discharge_acc) + 17'(sc2[39:24]);
        // A zero threshold would count every conversion, so it disables cycles
        if (st_q.cfg.cycle_increment_threshold != 16'h0000 &&
            dsum >= 17'(st_q.cfg.cycle_increment_threshold)) begin
          st_d.cycle_count = st_q.cycle_count + 16'h0001; // R23
          dsum = dsum - 17'(st_q.cfg.cycle_increment_threshold); // R23
        end
        st_d.discharge_acc = dsum[15:0];
      end
    end
    // Termination sync takes priority over counting in the same cycle
    if (charge_term && go.termination_capacity_sync) begin
      tgt = 24'(st_q.learned_full_capacity) * 24'(st_q.cfg.sync_percent); // R9
      tgt = tgt / `GCD_PCT_DIV; // R9
      st_d.remaining_capacity = tgt[15:0]; // R9
    end
    if (learn_done) begin
      st_d.learned_full_capacity = learned_capacity; // R21
    end
    // One-time correction request rearms at every reset
    if (midrange_done) begin
      st_d.one_time_pending = 1'b0; // R16
    end
    // Threshold selection
    if (!go.threshold_compensation_enable) begin
      pick = st_q.cfg.fixed_edv; // R11
    end
    if (go.fixed_lowest_threshold) begin
      pick.lowest_discharge_threshold = st_q.cfg.fixed_edv.lowest_discharge_threshold; // R8
      if (pick.middle < pick.lowest_discharge_threshold) begin
        pick.middle = pick.lowest_discharge_threshold; // R8
      end
      if (pick.upper < pick.lowest_discharge_threshold) begin
        pick.upper = pick.lowest_discharge_threshold; // R8
      end
    end
    st_d.edv = pick;
    st_d.eod_voltage = go.discharge_end_source ? pack_voltage : min_cell_voltage; // R12
    st_d.eod_reached = st_d.eod_voltage < pick.lowest_discharge_threshold; // R12
    ovv = 19'(max_cell_voltage) * 19'(cell_count); // R14
    st_d.ov_trip = go.overvoltage_source_select ? (ovv > 19'(ov_limit)) :
                   (pack_voltage > ov_limit); // R13 R14
    pw = 32'(st_q.cfg.pack_design_capacity) * 32'(st_q.cfg.design_voltage_setting); // R20
    pw = pw / `GCD_PWR_DIV; // R20
    st_d.design_capacity_report = power_mode ? pw[15:0] : st_q.cfg.pack_design_capacity; // R20
    st_d.filter_threshold_voltage = 17'(st_q.cfg.filter_threshold) * 17'(`GCD_FILT_NV); // R19
    st_d.led_on = led_next; // R1 R2
  end

  // Register the whole state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.cfg.charge_efficiency_code <= `GCD_RST_CHGEFF;
      st_q.cfg.sync_percent <= `GCD_RST_PCT;
      st_q.cfg.current_scale_gain <= `GCD_RST_GAIN;
      st_q.cfg.counter_gain_factor <= `GCD_RST_DELTA;
      st_q.cfg.initial_cycle_count <= `GCD_RST_HALF;
      st_q.cfg.filter_threshold <= `GCD_RST_BYTE;
      st_q.one_time_pending <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Zero wait states; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = st_q.prdata;
  assign led_on = st_q.led_on;
  assign host_alarm_pec = st_q.cfg.pack_options.host_alarm_check_enable; // R3
  assign charger_pec = st_q.cfg.pack_options.charger_broadcast_check_enable; // R4
  // Disable dominates so mode writes cannot bring broadcasts back
  assign broadcast_en = !st_q.cfg.pack_options.broadcast_disable && mode_broadcast_on; // R5 R6
  assign charger_type_select = st_q.cfg.gauge_options.charger_type_select; // R10
  assign edv = st_q.edv;
  assign eod_voltage = st_q.eod_voltage;
  assign eod_reached = st_q.eod_reached;
  assign ov_trip = st_q.ov_trip;
  assign midrange_req = go.midrange_correction_enable ||
                        (go.one_time_midrange_correction && st_q.one_time_pending); // R15 R16
  assign remaining_capacity = st_q.remaining_capacity;
  assign learned_full_capacity = st_q.learned_full_capacity;
  assign cycle_count = st_q.cycle_count;
  assign design_capacity_report = st_q.design_capacity_report;
  assign time_alarm = st_q.cfg.remaining_time_alarm_setting; // R22
  assign capacity_alarm = st_q.cfg.capacity_alarm_setting; // R22
  assign charge_mah = st_q.charge_mah;
  assign filter_threshold_voltage = st_q.filter_threshold_voltage;

  // Cell count decode; code 00 reports zero cells
  always_comb begin
    unique case (st_q.cfg.pack_options.series_cell_count)
      2'b11: cell_count = 3'd4; // R7
      2'b10: cell_count = 3'd3; // R7
      2'b01: cell_count = 3'd2; // R7
      2'b00: cell_count = 3'd0; // R26
    endcase
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_led_three_seg: assert property (po.led_count_field == 2'b01 |=> led_on[4:3] == 2'b00) // R2
    else $error("three-segment mode lit a fourth or fifth LED");
  a_led_rel_src: assert property (po.led_soc_select && rel_soc == 7'd0 |=> led_on == 5'h00) // R1
    else $error("relative source ignored for LEDs");
  a_bcast_block: assert property (po.broadcast_disable |-> !broadcast_en) // R5
    else $error("broadcast enabled while disabled");
  a_cells_four: assert property (po.series_cell_count == 2'b11 |-> cell_count == 3'd4) // R7
    else $error("four-cell code decoded wrong");
  a_edv_floor: assert property (go.fixed_lowest_threshold |=>
                                edv.middle >= edv.lowest_discharge_threshold &&
                                edv.upper >= edv.lowest_discharge_threshold) // R8
    else $error("upper thresholds below lowest");
  a_sync_hold: assert property (charge_term && !go.termination_capacity_sync && !conv_valid
                                |=> $stable(remaining_capacity)) // R9
    else $error("capacity changed at termination with sync off");
  a_offset_refresh: assert property (sleep_entry |=>
                                     st_q.cfg.counter_offset == $past(meas_counter_offset)) // R17
    else $error("counter offset not refreshed at sleep");
  a_ov_pack: assert property (!go.overvoltage_source_select && pack_voltage > ov_limit
                              |=> ov_trip) // R14
    else $error("pack overvoltage missed");
  a_once_clear: assert property (midrange_done && !go.midrange_correction_enable
                                 |=> !midrange_req) // R16
    else $error("one-time correction still requested");
  a_cycle_step: assert property (conv_valid && !conv_charging && !(psel && penable && pwrite)
                                 |=> cycle_count - $past(cycle_count) <= 16'h0001) // R23
    else $error("cycle count jumped by more than one");

  c_sync_load: cover property (charge_term && go.termination_capacity_sync);
  c_sleep: cover property (sleep_entry);
  c_cycle: cover property (conv_valid ##1 $changed(cycle_count));
endmodule

// file: bench/gcd_meas_model.sv
`timescale 1ns/10ps
// Measurement front end: new levels on each step, held steady in between
module gcd_meas_model(
  input wire logic clk,
  input wire logic step,
  output logic [15:0] pack_v = 16'h0000,
  output logic [15:0] min_v = 16'h0000,
  output logic [15:0] max_v = 16'h0000,
  output logic [15:0] lim = 16'h0000,
  output logic [6:0] asoc = 7'h00,
  output logic [6:0] rsoc = 7'h00
);
  logic [31:0] s = 32'h0000_5a5a;
  // Levels change only after a clock edge, so the gauge never sees a glitch
  always @(posedge clk) if (step) begin
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    {pack_v, min_v} <= s;
    {max_v, lim} <= {s[7:0], s[31:8]};
    asoc <= 7'(s[9:0] % 101);
    rsoc <= 7'(s[19:10] % 101);
  end
endmodule

// file: bench/test_gauge_config_decoder.sv
`timescale 1ns/10ps
`include "gcd_cfg.svh"
module test_gauge_config_decoder;
  import gcd_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, step = 0, se = 0, pm = 0, mb = 0;
  logic cv = 0, cg = 0, tm = 0, ld = 0, md = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, pr, rs = 32'h1e1c, x, e, y;
  logic [15:0] cr = 16'h0, lc = 16'h0, pv, nv, xv, ol, mco = 16'h0;
  logic [7:0] mgo = 8'h00, mao = 8'h00;
  logic [6:0] as, rl;
  gcd_edv_type ce = '0, ev;
  logic [4:0] led;
  logic [2:0] cc;
  logic hp, cp, be, ct, er, eod, rdy, ek, mr;
  logic [15:0] dcr, ta, rcap, lfc, cyc, ca, cm;
  logic [16:0] ftv;
  int err_count = 0, num_checks = 0;
  gcd_meas_model pm0(.clk(clk), .step(step), .pack_v(pv), .min_v(nv), .max_v(xv), .lim(ol),
    .asoc(as), .rsoc(rl));
  gcd_top uut(.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(pr), .pready(rdy), .pslverr(er), .abs_soc(as),
    .rel_soc(rl), .conv_result(cr), .conv_valid(cv), .conv_charging(cg),
    .charge_term(tm), .learn_done(ld), .learned_capacity(lc), .sleep_entry(se),
    .meas_counter_offset(mco), .meas_ground_offset(mgo), .meas_converter_offset(mao),
    .comp_edv(ce), .pack_voltage(pv), .min_cell_voltage(nv), .max_cell_voltage(xv),
    .ov_limit(ol), .power_mode(pm), .mode_broadcast_on(mb), .midrange_done(md),
    .led_on(led), .host_alarm_pec(hp), .charger_pec(cp), .broadcast_en(be), .cell_count(cc),
    .charger_type_select(ct), .edv(ev), .eod_voltage(), .eod_reached(eod), .ov_trip(),
    .midrange_req(mr), .remaining_capacity(rcap), .learned_full_capacity(lfc),
    .cycle_count(cyc), .design_capacity_report(dcr), .time_alarm(ta), .capacity_alarm(ca),
    .charge_mah(cm), .filter_threshold_voltage(ftv));
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Lit segments: segment i on when soc*n exceeds 100*i
  function automatic logic [4:0] led_exp(input logic [7:0] p, input logic [6:0] a, r);
    int n, s;
    n = p[6:5] == 2'b01 ? 3 : p[6:5] == 2'b10 ? 4 : 5;
    s = p[7] ? r : a;
    for (int i = 0; i < 5; i++) led_exp[i] = (i < n) && (s * n > 100 * i);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    num_checks++;
    if (g !== w) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, w);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d; penable <= 0;
    @(posedge clk) penable <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = pr;
    ek = er;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin #800000; err_count++; tally_and_finish(); end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    // Reset values, then an unmapped word
    apb(0, `GCD_IDX_CHGEFF, 0); chk(rd, 32'hff);
    apb(0, `GCD_IDX_GAIN, 0); chk(rd, 32'h77a1);
    apb(0, `GCD_IDX_DELTA, 0); chk(rd, 32'h0100_0000);
    apb(0, 10'h3ff, 0); chk({rd[0], ek}, 2'b01);
    // Every pack options code, broadcast request toggled at random
    for (int p = 0; p < 256; p++) begin
      mb <= 1'(rnd()); step <= 1;
      // One level step, then levels hold while the LED register settles
      @(posedge clk) step <= 0;
      apb(1, `GCD_IDX_PACK, p);
      @(posedge clk);
      e = p[1:0] == 2'b11 ? 4 : p[1:0] == 2'b10 ? 3 : p[1:0] == 2'b01 ? 2 : 0;
      chk({led, hp, cp, be, cc}, {led_exp(p, as, rl), p[4], p[3], !p[2] & mb, e[2:0]});
    end
    // Gauge options with lowest threshold fixed on or off: stored or computed set
    for (int k = 0; k < 40; k++) begin
      x = rnd() & 32'hff; ce <= 48'({rnd(), rnd()}); e = rnd(); step <= 1;
      apb(1, `GCD_IDX_GAUGE, x); step <= 0;
      apb(1, `GCD_IDX_EDVF0, e);
      // Thresholds are registered: one more edge
      @(posedge clk);
      y = x[4] ? ce[31:16] : 32'h0;
      if (x[7] && y[15:0] < e[15:0]) y = e[15:0];
      chk(ct, x[5]);
      chk(ev.lowest_discharge_threshold, x[4] && !x[7] ? ce[15:0] : e[15:0]);
      chk(ev.middle, y);
      chk(eod, (x[3] ? pv : nv) < (x[4] && !x[7] ? ce[15:0] : e[15:0]));
    end
    // Offsets rewritten on sleep entry
    {mco, mgo, mao} <= rnd();
    se <= 1; @(posedge clk) se <= 0; @(posedge clk);
    apb(0, `GCD_IDX_CCOFF, 0); chk(rd, mco);
    apb(0, `GCD_IDX_GNDOFF, 0); chk(rd, mgo);
    apb(0, `GCD_IDX_ADCOFF, 0); chk(rd, mao);
    // Capacity report in both units and the time alarm setting
    for (int k = 0; k < 8; k++) begin
      pm <= k[0]; e = rnd() % 5000; x = rnd() % 20000;
      apb(1, `GCD_IDX_FILT, x); apb(1, `GCD_IDX_CAPALM, x);
      apb(1, `GCD_IDX_DCAP, e); apb(1, `GCD_IDX_DV, x); apb(1, `GCD_IDX_RTA, x);
      chk(dcr, k[0] ? e * x / 10000 : e);
      chk(ftv, x[7:0] * 32'd290);
      chk(ta, x);
      chk(ca, x);
    end
    // Learning, a discharge, a half-efficiency charge, termination with sync off
    apb(1, `GCD_IDX_ICC, 0);
    apb(1, `GCD_IDX_CCT, 32'h50); apb(1, `GCD_IDX_CHGEFF, 32'h7f); apb(1, `GCD_IDX_GAUGE, 0);
    lc <= 16'h1000; ld <= 1; cr <= 16'h0100; cv <= 1;
    @(posedge clk) ld <= 0; cg <= 1;
    @(posedge clk) cv <= 0; tm <= 1;
    @(posedge clk) tm <= 0;
    @(posedge clk);
    chk(cyc, 1);
    chk(cm, (32'h100 * 32'h77a1) >> 16);
    chk(lfc, 32'h1000);
    chk(rcap, 32'h77 * 32'h80 >> 8);
    // Sync on, one-time correction armed since reset
    apb(1, `GCD_IDX_GAUGE, 32'h41); chk(mr, 1);
    tm <= 1; md <= 1;
    @(posedge clk) tm <= 0; md <= 0;
    @(posedge clk);
    chk(rcap, 32'h1000);
    chk(mr, 0);
    tally_and_finish();
  end
endmodule
